// ### rtl/three_wire_pkg.sv
// Constants, command codes, register map and state encodings of the three-wire register port.
// Assumes a 250 MHz core clock and a host that owns chip select and serial clock and shares the data line with the port.
package three_wire_pkg;

  // ==========================================================================
  // Frame layout
  localparam int FRAME_BITS = 16;
  localparam int CMD_W = 2;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;

  // ==========================================================================
  // Register map
  localparam logic [5:0] ADDR_POWER = 6'h00;
  localparam logic [5:0] ADDR_CONTROL = 6'h01;
  localparam logic [5:0] ADDR_CONFIG_FIRST = 6'h02;
  localparam logic [5:0] ADDR_CONFIG_SECOND = 6'h03;
  localparam logic [5:0] ADDR_HOLE = 6'h04;
  localparam logic [5:0] ADDR_OSC_DIVISOR = 6'h05;
  localparam logic [5:0] ADDR_SLEEP_HI = 6'h06;
  localparam logic [5:0] ADDR_SLEEP_LO = 6'h07;
  localparam logic [5:0] ADDR_HOST_WAKE = 6'h08;
  localparam logic [5:0] ADDR_SETTLE_HI = 6'h09;
  localparam logic [5:0] ADDR_SETTLE_LO = 6'h0a;
  localparam logic [5:0] ADDR_ACTIVE_HI = 6'h0b;
  localparam logic [5:0] ADDR_ACTIVE_LO = 6'h0c;
  localparam logic [5:0] ADDR_TX_LOW_HI = 6'h0d;
  localparam logic [5:0] ADDR_TX_LOW_LO = 6'h0e;
  localparam logic [5:0] ADDR_TX_HIGH_HI = 6'h0f;
  localparam logic [5:0] ADDR_TX_HIGH_LO = 6'h10;
  localparam logic [5:0] ADDR_STATUS = 6'h1a;
  localparam int REG_COUNT = 17;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int DRX_BIT = 4;
  localparam int STAT_LOCK = 7;
  localparam int STAT_GAIN = 6;
  localparam int STAT_CRYSTAL_REFERENCE = 5;
  localparam int STAT_PCAL = 1;
  localparam int STAT_FCAL = 0;

  // ==========================================================================
  // Synchroniser lanes
  localparam int SY_CS = 0;
  localparam int SY_SCLK = 1;
  localparam int SY_DIO = 2;
  localparam int SY_TGL = 3;
  localparam int SY_STAT = 4;
  localparam int SYNC_W = 9;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TIMER_TICK_US = 1;
  localparam int TICK_CYCLES_DEF = (TIMER_TICK_US * 1000000) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    DRX_IDLE = 3'b000,
    DRX_SLEEP = 3'b001,
    DRX_WAKE = 3'b010,
    DRX_SETTLE = 3'b011,
    DRX_ACTIVE = 3'b100,
    DRX_HELD = 3'b101
  } drx_state_t;

endpackage

// ### rtl/three_wire_register_port.sv
// Three-wire serial register port with its register bank and discontinuous-receive timer sequencer.
// Assumes the host drives chip select and serial clock, and the shared line is resolved outside with a pull-up.
`timescale 1ns/1ps
module three_wire_register_port
  import three_wire_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic shared_serial_line_in,
  output logic shared_serial_line_out,
  output logic shared_serial_line_oe,
  input wire logic pll_locked,
  input wire logic agc_high_gain,
  input wire logic crystal_running,
  input wire logic poll_cal_done,
  input wire logic fsk_cal_done,
  output logic [7:0] power_enables,
  output logic [7:0] control_flags,
  output logic [7:0] config_first,
  output logic [7:0] config_second,
  output logic [7:0] osc_divisor,
  output logic [15:0] sleep_time,
  output logic [7:0] host_wake_time,
  output logic [15:0] settle_time,
  output logic [15:0] active_time,
  output logic [15:0] tx_freq_low_word,
  output logic [15:0] tx_freq_high_word,
  output logic master_reset_active,
  output logic rx_power_on,
  output logic rx_data_enable,
  output logic peak_detect_enable
);

  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
    begin : g_bad_tick
      $error("TICK_CYCLES must lie between 1 and 65535.");
    end
  endgenerate

  // ==========================================================================
  // Link domain: shifting in on the serial clock
  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [14:0] shift;
  } frame_t;

  typedef struct packed {
    logic [1:0] cmd;
    logic [5:0] addr;
    logic [7:0] data;
    logic done_tgl;
  } hold_t;

  frame_t frame_q, frame_d;
  hold_t hold_q, hold_d;
  logic frame_rst_b;

  // The frame logic is cleared by select going high, so no serial clock edge is needed to end a frame.
  assign frame_rst_b = rst_b & ~cs_b;

  always_comb
  begin
    frame_d = frame_q;
    hold_d = hold_q;
    if (frame_q.bit_cnt < 5'(FRAME_BITS))
    begin
      frame_d.shift = {frame_q.shift[13:0], shared_serial_line_in};
      frame_d.bit_cnt = frame_q.bit_cnt + 5'd1;
      if (frame_q.bit_cnt == 5'(FRAME_BITS - 1))
      begin
        hold_d.cmd = frame_q.shift[14:13];
        hold_d.addr = frame_q.shift[12:7];
        hold_d.data = {frame_q.shift[6:0], shared_serial_line_in};
        hold_d.done_tgl = ~hold_q.done_tgl;
      end
    end
  end

  always_ff @(posedge sclk or negedge frame_rst_b)
  begin
    if (!frame_rst_b)
      frame_q <= '0;
    else
      frame_q <= frame_d;
  end

  // Held words change only on the last bit and are read by the core after the toggle has crossed.
  always_ff @(posedge sclk or negedge rst_b)
  begin
    if (!rst_b)
      hold_q <= '0;
    else
      hold_q <= hold_d;
  end

  // ==========================================================================
  // Core domain state
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0] status;
    logic read_pending;
    logic readback;
    logic [7:0] rdata;
    logic line_oe;
    logic line_out;
    logic mreset;
    drx_state_t drx_state;
    logic [15:0] drx_cnt;
    logic [15:0] tick_cnt;
    logic rx_power;
    logic rx_data;
  } core_t;

  core_t core_q, core_d;
  logic [SYNC_W-1:0] sync_in;
  logic cs_high, dio_high, cs_fall, cs_rise, sclk_rise, frame_evt, tick;
  logic [1:0] evt_cmd;
  logic [5:0] evt_addr;
  logic [7:0] evt_data;
  logic addr_mapped;

  assign sync_in = {fsk_cal_done, poll_cal_done, crystal_running, agc_high_gain, pll_locked,
                    hold_q.done_tgl, shared_serial_line_in, sclk, cs_b};
  assign cs_high = core_q.sync2[SY_CS];
  assign dio_high = core_q.sync2[SY_DIO];
  assign cs_fall = core_q.sync3[SY_CS] & ~core_q.sync2[SY_CS];
  assign cs_rise = ~core_q.sync3[SY_CS] & core_q.sync2[SY_CS];
  assign sclk_rise = ~core_q.sync3[SY_SCLK] & core_q.sync2[SY_SCLK];
  assign frame_evt = core_q.sync3[SY_TGL] ^ core_q.sync2[SY_TGL];
  assign tick = (core_q.tick_cnt == 16'h0000);
  assign evt_cmd = hold_q.cmd;
  assign evt_addr = hold_q.addr;
  assign evt_data = hold_q.data;
  assign addr_mapped = (evt_addr < 6'(REG_COUNT)) && (evt_addr != ADDR_HOLE);

  function automatic logic [7:0] read_byte(input logic [5:0] addr, input core_t c);
    logic [7:0] val;
    val = 8'h00;
    if (addr == ADDR_STATUS)
      val = c.status;
    else if (addr < 6'(REG_COUNT) && addr != ADDR_HOLE)
      val = c.regs[addr[4:0]];
    return val;
  endfunction

  always_comb
  begin
    core_d = core_q;
    core_d.sync1 = sync_in;
    core_d.sync2 = core_q.sync1;
    core_d.sync3 = core_q.sync2;
    core_d.status = 8'h00;
    core_d.status[STAT_LOCK] = core_q.sync2[SY_STAT];
    core_d.status[STAT_GAIN] = core_q.sync2[SY_STAT + 1];
    core_d.status[STAT_CRYSTAL_REFERENCE] = core_q.sync2[SY_STAT + 2];
    core_d.status[STAT_PCAL] = core_q.sync2[SY_STAT + 3];
    core_d.status[STAT_FCAL] = core_q.sync2[SY_STAT + 4];
    core_d.tick_cnt = tick ? 16'(TICK_CYCLES - 1) : core_q.tick_cnt - 16'h0001;

    // Frame decode; a read-back cycle carries no command, whatever the port's own read-back drive shifts in.
    if (frame_evt && !core_q.readback)
    begin
      unique case (evt_cmd)
        CMD_WRITE:
        begin
          if (addr_mapped)
            core_d.regs[evt_addr[4:0]] = evt_data;
        end
        CMD_READ:
        begin
          core_d.rdata = read_byte(evt_addr, core_q);
          core_d.read_pending = 1'b1;
        end
        CMD_RESET:
        begin
          core_d.mreset = 1'b1;
          core_d.read_pending = 1'b0;
        end
        CMD_NOP:
        begin
          core_d.mreset = core_q.mreset;
        end
      endcase
    end

    // Read-back: drive MSB at select fall, then shift after each sampled rising edge.
    if (cs_fall)
    begin
      core_d.mreset = frame_evt && !core_q.readback && (evt_cmd == CMD_RESET);
      if (core_q.read_pending)
      begin
        core_d.readback = 1'b1;
        core_d.read_pending = 1'b0;
        core_d.line_oe = 1'b1;
        core_d.line_out = core_q.rdata[7];
      end
    end
    else if (core_q.readback && !cs_high && sclk_rise)
    begin
      core_d.rdata = {core_q.rdata[6:0], 1'b0};
      core_d.line_out = core_q.rdata[6];
    end
    if (cs_rise)
    begin
      core_d.readback = 1'b0;
      core_d.line_oe = 1'b0;
      core_d.line_out = 1'b0;
    end

    // Discontinuous-receive sequencer.
    unique case (core_q.drx_state)
      DRX_IDLE:
      begin
        if (cs_high && dio_high && core_q.regs[ADDR_CONFIG_FIRST[4:0]][DRX_BIT])
        begin
          core_d.drx_state = DRX_SLEEP;
          core_d.drx_cnt = {core_q.regs[ADDR_SLEEP_HI[4:0]], core_q.regs[ADDR_SLEEP_LO[4:0]]};
        end
      end
      DRX_SLEEP:
      begin
        if (tick && core_q.drx_cnt == 16'h0000)
        begin
          core_d.drx_state = DRX_WAKE;
          core_d.drx_cnt = {8'h00, core_q.regs[ADDR_HOST_WAKE[4:0]]};
        end
        else if (tick)
          core_d.drx_cnt = core_q.drx_cnt - 16'h0001;
      end
      DRX_WAKE:
      begin
        if (tick && core_q.drx_cnt == 16'h0000)
        begin
          core_d.drx_state = DRX_SETTLE;
          core_d.drx_cnt = {core_q.regs[ADDR_SETTLE_HI[4:0]], core_q.regs[ADDR_SETTLE_LO[4:0]]};
        end
        else if (tick)
          core_d.drx_cnt = core_q.drx_cnt - 16'h0001;
      end
      DRX_SETTLE:
      begin
        if (tick && core_q.drx_cnt == 16'h0000)
        begin
          core_d.drx_state = DRX_ACTIVE;
          core_d.drx_cnt = {core_q.regs[ADDR_ACTIVE_HI[4:0]], core_q.regs[ADDR_ACTIVE_LO[4:0]]};
        end
        else if (tick)
          core_d.drx_cnt = core_q.drx_cnt - 16'h0001;
      end
      DRX_ACTIVE:
      begin
        if (tick && core_q.drx_cnt == 16'h0000)
        begin
          // A host that is not pulling the line low when the active time ends gets the whole sequence again.
          core_d.drx_state = dio_high ? DRX_SLEEP : DRX_HELD;
          core_d.drx_cnt = {core_q.regs[ADDR_SLEEP_HI[4:0]], core_q.regs[ADDR_SLEEP_LO[4:0]]};
        end
        else if (tick)
          core_d.drx_cnt = core_q.drx_cnt - 16'h0001;
      end
      DRX_HELD:
      begin
        if (dio_high)
        begin
          core_d.drx_state = DRX_SLEEP;
          core_d.drx_cnt = {core_q.regs[ADDR_SLEEP_HI[4:0]], core_q.regs[ADDR_SLEEP_LO[4:0]]};
        end
      end
      default:
      begin
        core_d.drx_state = DRX_IDLE;
      end
    endcase
    if (!cs_high || !core_q.regs[ADDR_CONFIG_FIRST[4:0]][DRX_BIT])
      core_d.drx_state = DRX_IDLE;
    core_d.rx_power = (core_d.drx_state == DRX_SETTLE) || (core_d.drx_state == DRX_ACTIVE)
                      || (core_d.drx_state == DRX_HELD);
    core_d.rx_data = (core_d.drx_state == DRX_ACTIVE) || (core_d.drx_state == DRX_HELD);

    // Master reset wins over any write and holds the bank while select stays high.
    if (core_d.mreset)
    begin
      core_d.regs = {REG_COUNT{REG_RESET}};
      core_d.drx_state = DRX_IDLE;
      core_d.rx_power = 1'b0;
      core_d.rx_data = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      core_q <= '0;
      core_q.regs <= {REG_COUNT{REG_RESET}};
      core_q.drx_state <= DRX_IDLE;
    end
    else
      core_q <= core_d;
  end

  // ==========================================================================
  // Outputs
  assign shared_serial_line_out = core_q.line_out;
  assign shared_serial_line_oe = core_q.line_oe;
  assign power_enables = core_q.regs[ADDR_POWER[4:0]];
  assign control_flags = core_q.regs[ADDR_CONTROL[4:0]];
  assign config_first = core_q.regs[ADDR_CONFIG_FIRST[4:0]];
  assign config_second = core_q.regs[ADDR_CONFIG_SECOND[4:0]];
  assign osc_divisor = core_q.regs[ADDR_OSC_DIVISOR[4:0]];
  assign sleep_time = {core_q.regs[ADDR_SLEEP_HI[4:0]], core_q.regs[ADDR_SLEEP_LO[4:0]]};
  assign host_wake_time = core_q.regs[ADDR_HOST_WAKE[4:0]];
  assign settle_time = {core_q.regs[ADDR_SETTLE_HI[4:0]], core_q.regs[ADDR_SETTLE_LO[4:0]]};
  assign active_time = {core_q.regs[ADDR_ACTIVE_HI[4:0]], core_q.regs[ADDR_ACTIVE_LO[4:0]]};
  assign tx_freq_low_word = {core_q.regs[ADDR_TX_LOW_HI[4:0]], core_q.regs[ADDR_TX_LOW_LO[4:0]]};
  assign tx_freq_high_word = {core_q.regs[ADDR_TX_HIGH_HI[4:0]], core_q.regs[ADDR_TX_HIGH_LO[4:0]]};
  assign master_reset_active = core_q.mreset;
  assign rx_power_on = core_q.rx_power;
  assign rx_data_enable = core_q.rx_data;
  assign peak_detect_enable = core_q.rx_data;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_oe_only_selected: assert property (shared_serial_line_oe |-> !$past(cs_high) && core_q.readback)
    else $error("Line driven outside a read-back cycle.");

  a_readback_drives: assert property (cs_fall && core_q.read_pending |=> shared_serial_line_oe
                                      && shared_serial_line_out == $past(core_q.rdata[7]))
    else $error("Read-back did not start driving the line.");

  a_write_lands: assert property (frame_evt && !core_q.readback && evt_cmd == CMD_WRITE && addr_mapped
                                  && !core_q.mreset |=> core_q.regs[$past(evt_addr[4:0])] == $past(evt_data))
    else $error("Write did not reach the register.");

  a_hole_protect: assert property (frame_evt && evt_cmd == CMD_WRITE && !addr_mapped |=> $stable(core_q.regs))
    else $error("Write to an unassigned address changed the bank.");

  a_unmapped_zero: assert property (frame_evt && !core_q.readback && evt_cmd == CMD_READ && !addr_mapped
                                    && evt_addr != ADDR_STATUS |=> core_q.rdata == 8'h00)
    else $error("Unassigned read returned nonzero data.");

  a_reset_cmd: assert property (frame_evt && !core_q.readback && evt_cmd == CMD_RESET |=> master_reset_active)
    else $error("Master reset command not taken.");

  a_reset_holds: assert property (master_reset_active && cs_high |=> core_q.regs == {REG_COUNT{REG_RESET}}
                                  && power_enables == REG_RESET)
    else $error("Registers left reset while select was high.");

  a_settle_quiet: assert property (core_q.drx_state == DRX_SETTLE
                                   |-> rx_power_on && !rx_data_enable && !peak_detect_enable)
    else $error("Data path enabled during settling.");

  a_drx_start: assert property (core_q.drx_state == DRX_IDLE && cs_high && dio_high && config_first[DRX_BIT]
                                && !core_d.mreset |=> core_q.drx_state == DRX_SLEEP)
    else $error("Timer sequence did not start.");

  c_write_frame: cover property (frame_evt && evt_cmd == CMD_WRITE && addr_mapped);
  c_read_back: cover property (cs_fall && core_q.read_pending ##[1:1000] cs_rise);
  c_master_reset: cover property (master_reset_active ##1 cs_fall);
  c_drx_active: cover property (core_q.drx_state == DRX_SETTLE ##1 core_q.drx_state == DRX_ACTIVE);

endmodule

// ### verification/host_model.sv
// Host side of the three-wire port: drives select, serial clock and its share of the data line.
// Assumes the bench resolves the line with a pull-up and calls one task at a time.
`timescale 1ns/1ps
module host_model
(
  output logic cs_b,
  output logic sclk,
  output logic line_drive,
  output logic line_oe,
  input wire logic line_level
);
  // ==========================================================================
  // Frames
  localparam realtime HALF = 62.5;

  initial
  begin
    cs_b = 1'b1;
    sclk = 1'b0;
    line_drive = 1'b0;
    line_oe = 1'b1;
  end

  // The serial clock stands still between frames, so the device sees no stray edges.
  task automatic frame(input logic [1:0] cmd, input logic [5:0] addr, input logic [7:0] data);
    logic [15:0] word;
    word = {cmd, addr, data};
    line_oe = 1'b1;
    cs_b = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      line_drive = word[i];
      #(HALF) sclk = 1'b1;
      #(HALF) sclk = 1'b0;
    end
    #(HALF) cs_b = 1'b1;
    line_drive = 1'b0;
    #(HALF);
  endtask

  // Each bit is taken just before the rising edge that moves the device to the next one.
  task automatic read_byte(input int pulses, output logic [7:0] data);
    line_oe = 1'b0;
    cs_b = 1'b0;
    for (int i = 0; i < pulses; i++)
    begin
      #(HALF) if (i < 8) data[7 - i] = line_level;
      sclk = 1'b1;
      #(HALF) sclk = 1'b0;
    end
    #(HALF) cs_b = 1'b1;
    line_drive = 1'b0;
    line_oe = 1'b1;
    #(2 * HALF);
  endtask

  task automatic hold_line(input logic low);
    line_drive = 1'b0;
    line_oe = low;
  endtask
endmodule

// ### verification/three_wire_register_port_test.sv
// Self-checking bench of the three-wire register port: writes, reads, refusals, master reset, sequencer.
// Assumes the host model owns select, serial clock and its drive; the bench resolves the line.
`timescale 1ns/1ps
module three_wire_register_port_test;
  import three_wire_pkg::*;
  // ==========================================================================
  // Harness
  localparam int TICKS = 2;
  localparam int LIMIT = 80000;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] stat = 5'h00;
  logic cs_b, sclk, host_drive, host_oe, dev_out, dev_oe, line;
  logic [7:0] power_enables, control_flags, config_first, config_second, osc_divisor, host_wake_time;
  logic [15:0] sleep_time, settle_time, active_time, tx_freq_low_word, tx_freq_high_word;
  logic master_reset_active, rx_power_on, rx_data_enable, peak_detect_enable;
  logic [7:0] exp_reg [64];
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  always #2 clk = ~clk;
  // The pull-up wins whenever neither side drives the line.
  assign line = dev_oe ? dev_out : (host_oe ? host_drive : 1'b1);

  three_wire_register_port #(.TICK_CYCLES(TICKS)) i_three_wire_register_port (
    .clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .shared_serial_line_in(line),
    .shared_serial_line_out(dev_out), .shared_serial_line_oe(dev_oe), .pll_locked(stat[4]),
    .agc_high_gain(stat[3]), .crystal_running(stat[2]), .poll_cal_done(stat[1]), .fsk_cal_done(stat[0]),
    .power_enables(power_enables), .control_flags(control_flags), .config_first(config_first),
    .config_second(config_second), .osc_divisor(osc_divisor), .sleep_time(sleep_time),
    .host_wake_time(host_wake_time), .settle_time(settle_time), .active_time(active_time),
    .tx_freq_low_word(tx_freq_low_word), .tx_freq_high_word(tx_freq_high_word),
    .master_reset_active(master_reset_active), .rx_power_on(rx_power_on),
    .rx_data_enable(rx_data_enable), .peak_detect_enable(peak_detect_enable));

  host_model i_host_model (.cs_b(cs_b), .sclk(sclk), .line_drive(host_drive), .line_oe(host_oe), .line_level(line));

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] e);
    num_checks++;
    if (seen !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, e, seen);
    end
  endtask

  task automatic check_regs();
    check("power", power_enables, exp_reg[0]);
    check("control", control_flags, exp_reg[1]);
    check("config_first", config_first, exp_reg[2]);
    check("config_second", config_second, exp_reg[3]);
    check("osc", osc_divisor, exp_reg[5]);
    check("sleep", sleep_time, {exp_reg[6], exp_reg[7]});
    check("wake", host_wake_time, exp_reg[8]);
    check("settle", settle_time, {exp_reg[9], exp_reg[10]});
    check("active", active_time, {exp_reg[11], exp_reg[12]});
    check("tx_low", tx_freq_low_word, {exp_reg[13], exp_reg[14]});
    check("tx_high", tx_freq_high_word, {exp_reg[15], exp_reg[16]});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_host_model.frame(CMD_WRITE, a, d);
    if (a <= ADDR_TX_HIGH_LO && a != ADDR_HOLE)
      exp_reg[a] = d;
  endtask

  task automatic rd(input logic [5:0] a, input int pulses, input logic [7:0] e);
    logic [7:0] got;
    i_host_model.frame(CMD_READ, a, 8'h00);
    i_host_model.read_byte(pulses, got);
    check("read", {8'h00, got}, {8'h00, e});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_write_read();
    check_regs();
    for (int a = 0; a <= 16; a++)
      wr(6'(a), 8'(a * 29 + 49));
    check_regs();
    for (int a = 0; a <= 16; a++)
      rd(6'(a), a[0] ? 8 : 16, exp_reg[a]);
    $display("done write and read");
  endtask

  task automatic t_refused();
    logic [4:0] s;
    i_host_model.frame(CMD_NOP, ADDR_POWER, 8'hff);
    wr(ADDR_STATUS, 8'hff);
    wr(ADDR_HOLE, 8'hff);
    wr(6'h3f, 8'hff);
    check_regs();
    rd(ADDR_HOLE, 8, 8'h00);
    rd(6'h3f, 16, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      s = i[0] ? 5'h0a : 5'h15;
      @(posedge clk) stat <= s;
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS, 8, {s[4:2], 3'b000, s[1:0]});
    end
    $display("done refused");
  endtask

  task automatic t_master_reset();
    i_host_model.frame(CMD_RESET, ADDR_POWER, 8'h00);
    exp_reg = '{default: 8'h00};
    repeat (100) @(posedge clk);
    check("mreset", master_reset_active, 1'b1);
    check_regs();
    wr(ADDR_OSC_DIVISOR, 8'h3c);
    check("mreset", master_reset_active, 1'b0);
    check_regs();
    $display("done master reset");
  endtask

  task automatic t_drx();
    wr(ADDR_SLEEP_LO, 8'h02);
    wr(ADDR_HOST_WAKE, 8'h01);
    wr(ADDR_SETTLE_LO, 8'h03);
    wr(ADDR_ACTIVE_LO, 8'h04);
    wr(ADDR_CONFIG_FIRST, 8'h10);
    repeat (60) @(posedge clk);
    check("rx_power", rx_power_on, 1'b0);
    i_host_model.hold_line(1'b0);
    repeat (8) @(posedge clk);
    check("rx_power", rx_power_on, 1'b0);
    for (int n = 0; n < 40 && rx_power_on !== 1'b1; n++)
      @(posedge clk);
    check("rx_power", rx_power_on, 1'b1);
    check("rx_data", rx_data_enable, 1'b0);
    check("peak", peak_detect_enable, 1'b0);
    repeat (6) @(posedge clk);
    check("rx_data", rx_data_enable, 1'b0);
    for (int n = 0; n < 20 && rx_data_enable !== 1'b1; n++)
      @(posedge clk);
    check("rx_data", rx_data_enable, 1'b1);
    check("peak", peak_detect_enable, 1'b1);
    i_host_model.hold_line(1'b1);
    repeat (60) @(posedge clk);
    check("held", rx_data_enable, 1'b1);
    i_host_model.hold_line(1'b0);
    for (int n = 0; n < 20 && rx_power_on !== 1'b0; n++)
      @(posedge clk);
    check("rx_power", rx_power_on, 1'b0);
    i_host_model.hold_line(1'b1);
    wr(ADDR_CONFIG_FIRST, 8'h00);
    $display("done sequencer");
  endtask

  initial
  begin
    exp_reg = '{default: 8'h00};
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_write_read();
    t_refused();
    t_master_reset();
    t_drx();
    test_done();
  end
endmodule
